// ### core/fpm_map.vh
`ifndef FPM_MAP_VH
`define FPM_MAP_VH
// menu items, in select order
`define FPM_ITEM_MSG     3'h0
`define FPM_ITEM_BRIGHT  3'h1
`define FPM_ITEM_ADDR    3'h2
`define FPM_ITEM_JUST    3'h3
`define FPM_ITEM_ERROR   3'h4
`define FPM_ITEM_MODE    3'h5
`define FPM_ITEM_RESTORE 3'h6
`define FPM_ITEM_LAST    3'h6
`define FPM_ITEM_FIRST_DYN 3'h3
// display sources
`define FPM_SHOW_STATIC  3'h0
`define FPM_SHOW_DYNAMIC 3'h1
`define FPM_SHOW_WAIT    3'h2
`define FPM_SHOW_LOSS    3'h3
`define FPM_SHOW_BLOCK   3'h4
`define FPM_SHOW_MENU    3'h5
// justification codes: 0, L, C, R
`define FPM_JUST_NONE    2'h0
// error settings
`define FPM_ERR_TEXT     2'h0
`define FPM_ERR_BLOCK    2'h1
`define FPM_ERR_STATIC   2'h2
`define FPM_ERR_KEEP     2'h3
// factory restore defaults
`define FPM_DEF_ADDR     7'h00
`define FPM_DEF_SIDE     1'h0
`define FPM_DEF_JUST     2'h0
`define FPM_DEF_ERR      2'h0
`define FPM_DEF_MODE     1'h1
`define FPM_ADDR_MAX     7'h7D
`define FPM_MSG_LEN      4'h8
`define FPM_CLK_HZ       20000000
`define FPM_DEBOUNCE_MS  20
`define FPM_DEBOUNCE_CYC ((`FPM_CLK_HZ / 1000) * `FPM_DEBOUNCE_MS)
`define FPM_LOSS_MS      2000
`define FPM_LOSS_CYC     ((`FPM_CLK_HZ / 1000) * `FPM_LOSS_MS)
`endif

// ### core/fpm_debounce.v
`timescale 1ns/1ps
`include "fpm_map.vh"
module fpm_debounce #(
  parameter integer STABLE_CYC = `FPM_DEBOUNCE_CYC
) (
  // clock and reset
  input  wire sys_clk,
  input  wire rst,
  // button
  input  wire btn_raw,
  output reg  press_q
);
  reg        s1_q;
  reg        s2_q;
  reg        level_q;
  reg [31:0] cnt_q;
  // two-flop synchroniser, then require a stable level
  always @(posedge sys_clk) begin
    if (rst) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      level_q <= 1'b0;
      cnt_q   <= 32'h0;
      press_q <= 1'b0;
    end else begin
      s1_q    <= btn_raw;
      s2_q    <= s1_q;
      press_q <= 1'b0;
      if (s2_q == level_q) begin
        cnt_q <= 32'h0;
      end else if (cnt_q >= STABLE_CYC - 1) begin
        cnt_q   <= 32'h0;
        level_q <= s2_q;
        press_q <= s2_q;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end
endmodule // fpm_debounce

// ### core/fpm_link_watch.v
`timescale 1ns/1ps
`include "fpm_map.vh"
module fpm_link_watch #(
  parameter integer LOSS_CYC = `FPM_LOSS_CYC
) (
  // clock and reset
  input  wire sys_clk,
  input  wire rst,
  // traffic
  input  wire frame_ok,
  output reg  loss_q
);
  reg [31:0] idle_q;
  // loss only after a full quiet period; any good frame clears it
  always @(posedge sys_clk) begin
    if (rst) begin
      idle_q <= 32'h0;
      loss_q <= 1'b0;
    end else if (frame_ok) begin
      idle_q <= 32'h0;
      loss_q <= 1'b0;
    end else if (idle_q >= LOSS_CYC - 1) begin
      loss_q <= 1'b1;
    end else begin
      idle_q <= idle_q + 32'h1;
    end
  end
endmodule // fpm_link_watch

// ### core/fpm_menu.v
`timescale 1ns/1ps
`include "fpm_map.vh"
// Summary of operation
// - lower button steps through seven items
// - start static, go dynamic on valid frame
// - dynamic mode offers only last four items
// - upper edits, lower alters, upper stores
// - dynamic save shows waiting until addressed
// - message editing only in mode 0
// - per-character cursor edit, eight characters
// - brightness editable only static, live display
// - lower changes brightness, upper press saves
// - address edited digit by digit
// - address accepted only 000 to 125
// - waiting persists until own address arrives
// - justification applies only to serial text
// - link loss shown per error setting
// - mode 0 ignores serial message and tally
// - mode 1 accepts serial message and tally
// - mode 0 buttons create messages regardless
// - factory restore sets documented defaults
// - restore item offers No, then Yes
// - restore applies after power cycle only
module fpm_menu #(
  parameter integer DEBOUNCE_CYC = `FPM_DEBOUNCE_CYC,
  parameter integer LOSS_CYC     = `FPM_LOSS_CYC,
  parameter integer BRIGHT_W     = 3
) (
  // clock and reset
  input  wire                sys_clk,
  input  wire                rst,
  // power-up marker: high for the first cycles after power is applied
  input  wire                power_up,
  // buttons
  input  wire                btn_select,
  input  wire                btn_change,
  // serial receiver results
  input  wire                rx_valid,
  input  wire [6:0]          rx_addr,
  input  wire                rx_tally_l,
  input  wire                rx_tally_r,
  input  wire [BRIGHT_W-1:0] rx_bright,
  // display state
  output reg  [2:0]          show_src_q,
  output reg  [2:0]          menu_item_q,
  output reg                 edit_q,
  output reg  [3:0]          cursor_q,
  output reg  [7:0]          edit_char_q,
  output reg  [BRIGHT_W-1:0] bright_q,
  output reg                 tally_l_q,
  output reg                 tally_r_q,
  output reg                 msg_we_q,
  output reg  [2:0]          msg_wa_q,
  output reg  [7:0]          msg_wd_q,
  // configuration
  output reg  [6:0]          addr_q,
  output reg  [1:0]          just_q,
  output reg  [1:0]          err_q,
  output reg                 mode_q,
  output reg                 side_q,
  output reg                 dynamic_q,
  output reg                 restore_pend_q,
  output reg                 loss_q
);
  wire       sel_p;
  wire       chg_p;
  wire       link_loss;
  reg  [BRIGHT_W-1:0] bright_cfg_q;
  reg  [BRIGHT_W-1:0] bright_rx_q;
  reg  [3:0] dig_q [0:2];
  reg        restore_yes_q;
  reg        waiting_q;
  reg        dyn_msg_q;
  reg  [2:0] next_item;
  reg  [9:0] addr_sum;

  fpm_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_db_sel (
    .sys_clk (sys_clk),
    .rst     (rst),
    .btn_raw (btn_select),
    .press_q (sel_p)
  );
  fpm_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_db_chg (
    .sys_clk (sys_clk),
    .rst     (rst),
    .btn_raw (btn_change),
    .press_q (chg_p)
  );
  fpm_link_watch #(.LOSS_CYC(LOSS_CYC)) u_watch (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .frame_ok (rx_valid & mode_q),
    .loss_q   (link_loss)
  );

  // item sequence; dynamic mode skips the message, brightness and address items
  always @* begin
    if (menu_item_q >= `FPM_ITEM_LAST)
      next_item = dynamic_q ? `FPM_ITEM_FIRST_DYN : `FPM_ITEM_MSG;
    // a frame can arrive while a static-only item is shown
    else if (dynamic_q && menu_item_q < `FPM_ITEM_FIRST_DYN)
      next_item = `FPM_ITEM_FIRST_DYN;
    else
      next_item = menu_item_q + 3'h1;
    addr_sum = {6'h00, dig_q[0]} * 10'd100 + {6'h00, dig_q[1]} * 10'd10
             + {6'h00, dig_q[2]};
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      menu_item_q   <= `FPM_ITEM_MSG;
      edit_q        <= 1'b0;
      cursor_q      <= 4'h0;
      edit_char_q   <= 8'h20;
      msg_we_q      <= 1'b0;
      msg_wa_q      <= 3'h0;
      msg_wd_q      <= 8'h00;
      bright_cfg_q  <= {BRIGHT_W{1'b0}};
      bright_rx_q   <= {BRIGHT_W{1'b0}};
      dig_q[0]      <= 4'h0;
      dig_q[1]      <= 4'h0;
      dig_q[2]      <= 4'h0;
      restore_yes_q <= 1'b0;
      waiting_q     <= 1'b0;
      dyn_msg_q     <= 1'b0;
      tally_l_q     <= 1'b0;
      tally_r_q     <= 1'b0;
      addr_q        <= `FPM_DEF_ADDR;
      just_q        <= `FPM_DEF_JUST;
      err_q         <= `FPM_DEF_ERR;
      mode_q        <= `FPM_DEF_MODE;
      side_q        <= `FPM_DEF_SIDE;
      dynamic_q     <= 1'b0;
      restore_pend_q <= 1'b0;
      loss_q        <= 1'b0;
    end else begin
      msg_we_q <= 1'b0;
      loss_q   <= link_loss & dynamic_q;
      // pending restore is applied only at the next power-up
      if (power_up && restore_pend_q) begin
        addr_q   <= `FPM_DEF_ADDR;
        just_q   <= `FPM_DEF_JUST;
        err_q    <= `FPM_DEF_ERR;
        mode_q   <= `FPM_DEF_MODE;
        side_q   <= `FPM_DEF_SIDE;
        restore_pend_q <= 1'b0;
      end
      // serial intake only in mode 1
      if (rx_valid && mode_q) begin
        dynamic_q   <= 1'b1;
        bright_rx_q <= rx_bright;
        if (rx_addr == addr_q) begin
          waiting_q <= 1'b0;
          dyn_msg_q <= 1'b1;
          tally_l_q <= rx_tally_l;
          tally_r_q <= rx_tally_r;
        end
      end
      if (!edit_q) begin
        if (sel_p) begin
          menu_item_q <= next_item;
        end else if (chg_p) begin
          case (menu_item_q)
            `FPM_ITEM_MSG: begin
              if (!mode_q) begin
                edit_q   <= 1'b1;
                cursor_q <= 4'h0;
              end
            end
            `FPM_ITEM_BRIGHT: edit_q <= !dynamic_q;
            `FPM_ITEM_ADDR: begin
              edit_q   <= 1'b1;
              cursor_q <= 4'h0;
            end
            `FPM_ITEM_RESTORE: begin
              edit_q        <= 1'b1;
              restore_yes_q <= 1'b0;
            end
            default: edit_q <= 1'b1;
          endcase
        end
      end else begin
        case (menu_item_q)
          `FPM_ITEM_MSG: begin
            if (sel_p)
              edit_char_q <= edit_char_q + 8'h01;
            else if (chg_p) begin
              msg_we_q <= 1'b1;
              msg_wa_q <= cursor_q[2:0];
              msg_wd_q <= edit_char_q;
              if (cursor_q == `FPM_MSG_LEN - 4'h1)
                edit_q <= 1'b0;
              else
                cursor_q <= cursor_q + 4'h1;
            end
          end
          `FPM_ITEM_BRIGHT: begin
            if (sel_p)
              bright_cfg_q <= bright_cfg_q + {{(BRIGHT_W-1){1'b0}}, 1'b1};
            else if (chg_p)
              edit_q <= 1'b0;
          end
          `FPM_ITEM_ADDR: begin
            if (sel_p)
              dig_q[cursor_q[1:0]] <= (dig_q[cursor_q[1:0]] == 4'h9) ?
                                      4'h0 : dig_q[cursor_q[1:0]] + 4'h1;
            else if (chg_p) begin
              if (cursor_q == 4'h2) begin
                cursor_q <= 4'h0;
                // an out-of-range entry stays in edit for correction
                if (addr_sum <= {3'h0, `FPM_ADDR_MAX}) begin
                  addr_q    <= addr_sum[6:0];
                  edit_q    <= 1'b0;
                  waiting_q <= dynamic_q;
                  dyn_msg_q <= 1'b0;
                end
              end else
                cursor_q <= cursor_q + 4'h1;
            end
          end
          `FPM_ITEM_RESTORE: begin
            if (sel_p)
              restore_yes_q <= 1'b1;
            else if (chg_p) begin
              edit_q <= 1'b0;
              if (restore_yes_q)
                restore_pend_q <= 1'b1;
            end
          end
          default: begin
            if (sel_p) begin
              if (menu_item_q == `FPM_ITEM_JUST)
                just_q <= just_q + 2'h1;
              else if (menu_item_q == `FPM_ITEM_ERROR)
                err_q <= err_q + 2'h1;
              else
                mode_q <= ~mode_q;
            end else if (chg_p) begin
              edit_q    <= 1'b0;
              waiting_q <= dynamic_q;
              dyn_msg_q <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // display source and live brightness
  always @(posedge sys_clk) begin
    if (rst) begin
      show_src_q <= `FPM_SHOW_STATIC;
      bright_q   <= {BRIGHT_W{1'b0}};
    end else begin
      bright_q <= dynamic_q ? bright_rx_q : bright_cfg_q;
      if (edit_q)
        show_src_q <= `FPM_SHOW_MENU;
      else if (!dynamic_q || !mode_q)
        show_src_q <= `FPM_SHOW_STATIC;
      else if (link_loss) begin
        case (err_q)
          `FPM_ERR_TEXT:   show_src_q <= `FPM_SHOW_LOSS;
          `FPM_ERR_BLOCK:  show_src_q <= `FPM_SHOW_BLOCK;
          `FPM_ERR_STATIC: show_src_q <= `FPM_SHOW_STATIC;
          default:         show_src_q <= dyn_msg_q ?
                             `FPM_SHOW_DYNAMIC : `FPM_SHOW_WAIT;
        endcase
      end else if (waiting_q || !dyn_msg_q)
        show_src_q <= `FPM_SHOW_WAIT;
      else
        show_src_q <= `FPM_SHOW_DYNAMIC;
    end
  end
endmodule // fpm_menu

// ### bench/fpm_asserts.sv
`timescale 1ns/1ps
module fpm_asserts #(
  parameter integer DEBOUNCE_CYC = 4
) (
  // clock and reset
  input wire       sys_clk,
  input wire       rst,
  // serial results
  input wire       rx_valid,
  // watched outputs
  input wire [2:0] show_src_q,
  input wire [2:0] menu_item_q,
  input wire       edit_q,
  input wire       msg_we_q,
  input wire [6:0] addr_q,
  input wire [1:0] err_q,
  input wire       mode_q,
  input wire       dynamic_q,
  input wire       tally_l_q,
  input wire       loss_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_item_in_range: assert property (menu_item_q <= 3'h6)
    else $error("menu item beyond last");
  a_dyn_from_frame: assert property ($rose(dynamic_q) |-> mode_q &&
    ($past(rx_valid) || $past(rx_valid, 2)))
    else $error("dynamic entered without a frame in mode 1");
  a_dyn_edit_items: assert property ($rose(edit_q) && dynamic_q
    |-> menu_item_q >= 3'h3)
    else $error("edit of a static-only item while dynamic");
  a_msg_mode_zero: assert property (msg_we_q |-> !mode_q)
    else $error("message written in mode 1");
  a_msg_we_pulse: assert property (msg_we_q |=> !msg_we_q)
    else $error("message write longer than one cycle");
  a_addr_limit: assert property (addr_q <= 7'h7D)
    else $error("stored address above 125");
  a_tally_ignored: assert property (!mode_q && $past(!mode_q)
    |-> $stable(tally_l_q))
    else $error("tally moved in mode 0");
  a_loss_text: assert property (show_src_q == 3'h3
    |-> loss_q && dynamic_q && err_q == 2'h0)
    else $error("loss text shown without cause");
  a_one_step: assert property ($changed(menu_item_q)
    |=> $stable(menu_item_q)[*3])
    else $error("menu stepped twice for one press");
  c_edit: cover property ($rose(edit_q));
  c_msg_write: cover property (msg_we_q);
  c_loss: cover property ($rose(loss_q));
endmodule // fpm_asserts

// ### bench/fpm_partner.sv
`timescale 1ns/1ps
module fpm_partner (
  // clock
  input wire       sys_clk,
  // buttons, high while pressed
  output reg       btn_select,
  output reg       btn_change,
  // receiver results
  output reg       rx_valid,
  output reg [6:0] rx_addr,
  output reg       rx_tally_l,
  output reg       rx_tally_r,
  output reg [2:0] rx_bright
);
  initial begin
    btn_select = 1'b0;
    btn_change = 1'b0;
    rx_valid = 1'b0;
    rx_addr = 7'h00;
    rx_tally_l = 1'b0;
    rx_tally_r = 1'b0;
    rx_bright = 3'h0;
  end
  // held well past the debounce window so one press is one action
  task press(input is_sel);
    begin
      @(negedge sys_clk);
      if (is_sel) btn_select = 1'b1;
      else btn_change = 1'b1;
      repeat (10) @(negedge sys_clk);
      btn_select = 1'b0;
      btn_change = 1'b0;
      repeat (10) @(negedge sys_clk);
    end
  endtask
  task frame(input [6:0] a, input tl);
    begin
      @(negedge sys_clk);
      rx_valid = 1'b1;
      rx_addr = a;
      rx_tally_l = tl;
      rx_tally_r = ~tl;
      rx_bright = 3'h5;
      @(negedge sys_clk);
      rx_valid = 1'b0;
      // stale address and left tally scrambled so nothing leans on them
      rx_addr = ~a;
      rx_tally_l = ~tl;
      repeat (4) @(negedge sys_clk);
    end
  endtask
endmodule // fpm_partner

// ### bench/fpm_menu_bench.sv
`timescale 1ns/1ps
module fpm_menu_bench;
  reg        sys_clk = 1'b0;
  reg        rst = 1'b1;
  reg        power_up = 1'b1;
  wire       btn_select, btn_change, rx_valid, rx_tally_l, rx_tally_r;
  wire [6:0] rx_addr, addr_q;
  wire [2:0] rx_bright, show_src_q, menu_item_q, bright_q, msg_wa_q;
  wire [3:0] cursor_q;
  wire [7:0] edit_char_q, msg_wd_q;
  wire [1:0] just_q, err_q;
  wire       edit_q, tally_l_q, tally_r_q, msg_we_q, mode_q, side_q;
  wire       dynamic_q, restore_pend_q, loss_q;
  integer    fails, samples_checked, we_count, i;
  reg  [2:0] b;
  reg  [7:0] c;
  always #25 sys_clk = ~sys_clk;
  fpm_menu #(.DEBOUNCE_CYC(4), .LOSS_CYC(300)) dut (.sys_clk, .rst,
    .power_up, .btn_select, .btn_change, .rx_valid, .rx_addr, .rx_tally_l,
    .rx_tally_r, .rx_bright, .show_src_q, .menu_item_q, .edit_q, .cursor_q,
    .edit_char_q, .bright_q, .tally_l_q, .tally_r_q, .msg_we_q, .msg_wa_q,
    .msg_wd_q, .addr_q, .just_q, .err_q, .mode_q, .side_q, .dynamic_q,
    .restore_pend_q, .loss_q);
  fpm_partner pm (.sys_clk, .btn_select, .btn_change, .rx_valid, .rx_addr,
    .rx_tally_l, .rx_tally_r, .rx_bright);
  always @(posedge sys_clk) if (msg_we_q === 1'b1) we_count <= we_count + 1;
  task close_out;
    begin
      if (fails == 0 && samples_checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tap(input integer n, input is_sel);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) pm.press(is_sel);
    end
  endtask
  // bounded walk, so a stuck menu shows up as a mismatch
  task goto(input [2:0] item);
    integer k;
    begin
      for (k = 0; k < 8 && menu_item_q !== item; k = k + 1) pm.press(1'b1);
      chk(menu_item_q, item);
    end
  endtask
  task edit_toggle;
    begin
      tap(1, 1'b0);
      tap(1, 1'b1);
      tap(1, 1'b0);
    end
  endtask
  initial begin
    #2000000;
    fails = fails + 1;
    close_out;
  end
  initial begin
    fails = 0;
    samples_checked = 0;
    we_count = 0;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    power_up = 1'b0;
    @(negedge sys_clk);
    chk({mode_q, side_q, dynamic_q, just_q, err_q}, 8'h40);
    chk({show_src_q, menu_item_q, addr_q == 7'h00}, 8'h01);
    for (i = 0; i < 7; i = i + 1) begin
      tap(1, 1'b1);
      chk(menu_item_q, (i + 1) % 7);
    end
    tap(1, 1'b0);
    chk(edit_q, 8'h00);
    goto(3'h2);
    tap(1, 1'b0);
    tap(1, 1'b1);
    tap(3, 1'b0);
    chk({edit_q, addr_q}, 8'd100);
    tap(1, 1'b0);
    tap(1, 1'b1);
    tap(3, 1'b0);
    chk({edit_q, addr_q}, 8'h80 | 8'd100);
    tap(8, 1'b1);
    tap(3, 1'b0);
    chk({edit_q, addr_q}, 8'h00);
    goto(3'h5);
    edit_toggle;
    chk(mode_q, 8'h00);
    pm.frame(7'h00, 1'b1);
    chk({dynamic_q, tally_l_q, tally_r_q, bright_q}, 8'h00);
    goto(3'h0);
    tap(1, 1'b0);
    chk(edit_q, 8'h01);
    c = edit_char_q;
    for (i = 0; i < 8; i = i + 1) begin
      chk(cursor_q, i);
      tap(1, 1'b1);
      chk(edit_char_q, c + i + 1);
      pm.frame(7'h00, 1'b1);
      tap(1, 1'b0);
      chk(msg_wa_q, i);
      chk(msg_wd_q, c + i + 1);
    end
    chk(we_count, 8'h08);
    chk({edit_q, show_src_q}, 8'h00);
    goto(3'h1);
    tap(1, 1'b0);
    b = bright_q;
    tap(1, 1'b1);
    chk(bright_q === b, 8'h00);
    tap(1, 1'b0);
    chk(edit_q, 8'h00);
    goto(3'h5);
    edit_toggle;
    chk(mode_q, 8'h01);
    pm.frame(7'h00, 1'b1);
    chk({dynamic_q, tally_l_q, tally_r_q, bright_q}, 8'h35);
    for (i = 0; i < 5; i = i + 1) begin
      tap(1, 1'b1);
      chk(menu_item_q >= 3'h3, 8'h01);
    end
    pm.frame(7'h00, 1'b0);
    goto(3'h3);
    edit_toggle;
    chk({just_q, show_src_q}, 8'h0A);
    pm.frame(7'h05, 1'b0);
    chk(show_src_q, 8'h02);
    pm.frame(7'h00, 1'b0);
    chk(show_src_q, 8'h01);
    for (i = 0; i < 400 && loss_q !== 1'b1; i = i + 1) @(negedge sys_clk);
    chk({loss_q, show_src_q}, 8'h0B);
    pm.frame(7'h00, 1'b0);
    chk(loss_q, 8'h00);
    goto(3'h4);
    edit_toggle;
    for (i = 0; i < 400 && loss_q !== 1'b1; i = i + 1) @(negedge sys_clk);
    chk({err_q, loss_q, show_src_q}, 8'h1C);
    goto(3'h6);
    edit_toggle;
    chk({restore_pend_q, just_q}, 8'h05);
    power_up = 1'b1;
    repeat (2) @(negedge sys_clk);
    power_up = 1'b0;
    @(negedge sys_clk);
    chk({mode_q, side_q, just_q, err_q, addr_q == 7'h00}, 8'h41);
    close_out;
  end
endmodule // fpm_menu_bench
bind fpm_menu fpm_asserts #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_asserts (
  .sys_clk, .rst, .rx_valid, .show_src_q, .menu_item_q, .edit_q, .msg_we_q,
  .addr_q, .err_q, .mode_q, .dynamic_q, .tally_l_q, .loss_q);
